//--- tb/asf_status_test.sv
// Self-checking bench for the ALU status and pointer mode block
`timescale 1ns/10ps
module asf_status_test;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic              mclk, rst_n, clk_en, acc_a, acc_b, ptr_a_wr, ptr_b_wr;
  logic [7:0]        ptr_wdata, rdata, pa, pb, status;
  asf_pkg::asf_bus_s bus;
  asf_pkg::asf_req_s req;
  asf_pkg::asf_res_s res;
  int                err_count = 0;
  int                n_compared = 0;

  asf_status u_dut (.mclk(mclk), .rst_n(rst_n), .clk_en(clk_en), .bus(bus), .rdata(rdata),
    .req(req), .res(res), .acc_a(acc_a), .acc_b(acc_b), .ptr_a_wr(ptr_a_wr),
    .ptr_b_wr(ptr_b_wr), .ptr_wdata(ptr_wdata), .indirect_pointer_a(pa),
    .indirect_pointer_b(pb), .status(status));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic end_of_test();
    if (err_count == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_of_test

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    bus.addr <= a; bus.wdata <= d; bus.wr <= 1'b1;
    @(posedge mclk);
    bus.wr <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk);
    bus.addr <= a; bus.rd <= 1'b1;
    @(posedge mclk);
    bus.rd <= 1'b0;
    #1 check(rdata, exp);
  endtask : reg_rd

  task automatic alu(input asf_pkg::asf_op_e op, input logic [7:0] a, input logic [7:0] b,
                     input logic [7:0] er, input logic [3:0] ef);
    @(posedge mclk);
    req.op <= op; req.a <= a; req.b <= b;
    @(posedge mclk);
    req.op <= asf_pkg::ASF_OP_NONE;
    #1 check(res.result, er);
    check({4'h0, res.flags}, {4'h0, ef});
  endtask : alu

  task automatic test_ptr();
    for (int m = 0; m < 4; m++) begin
      reg_wr(8'h04, {m[1:0], ~m[1:0], 4'h0});
      @(posedge mclk);
      ptr_a_wr <= 1'b1; ptr_b_wr <= 1'b1; ptr_wdata <= 8'h10;
      @(posedge mclk);
      ptr_a_wr <= 1'b0; ptr_b_wr <= 1'b0; acc_a <= 1'b1; acc_b <= 1'b1;
      @(posedge mclk);
      acc_a <= 1'b0; acc_b <= 1'b0;
      #1 check(pa, m == 3 ? 8'h0F : (m == 2 ? 8'h11 : 8'h10));
      check(pb, m == 0 ? 8'h0F : (m == 1 ? 8'h11 : 8'h10));
    end
  endtask : test_ptr

  task automatic test_override();
    @(posedge mclk);
    bus.addr <= 8'h04; bus.wdata <= 8'h3F; bus.wr <= 1'b1;
    req.op <= asf_pkg::ASF_OP_ADD; req.a <= 8'h01; req.b <= 8'h01;
    @(posedge mclk);
    bus.wr <= 1'b0; req.op <= asf_pkg::ASF_OP_NONE;
    #1 check(status, 8'h30);
    @(posedge mclk);
    clk_en <= 1'b0; req.op <= asf_pkg::ASF_OP_ADD; req.a <= 8'hFF;
    @(posedge mclk);
    req.op <= asf_pkg::ASF_OP_NONE; clk_en <= 1'b1;
    #1 check(status, 8'h30);
  endtask : test_override

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_n = 1'b0; clk_en = 1'b1; bus = '0; req = '{asf_pkg::ASF_OP_NONE, 8'h00, 8'h00};
    acc_a = 1'b0; acc_b = 1'b0; ptr_a_wr = 1'b0; ptr_b_wr = 1'b0; ptr_wdata = 8'h00;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    reg_rd(8'h04, 8'hF0);
    reg_rd(8'h05, 8'h00);
    test_ptr();
    alu(asf_pkg::ASF_OP_ADD, 8'h7F, 8'h01, 8'h80, 4'hA);
    alu(asf_pkg::ASF_OP_ADD, 8'hFF, 8'h01, 8'h00, 4'h7);
    alu(asf_pkg::ASF_OP_SUB, 8'h05, 8'h05, 8'h00, 4'h7);
    alu(asf_pkg::ASF_OP_SUB, 8'h80, 8'h01, 8'h7F, 4'h9);
    alu(asf_pkg::ASF_OP_RRC, 8'h02, 8'h00, 8'h81, 4'h8);
    alu(asf_pkg::ASF_OP_RLC, 8'h00, 8'h00, 8'h00, 4'hC);
    alu(asf_pkg::ASF_OP_RLC, 8'h80, 8'h00, 8'h00, 4'hD);
    alu(asf_pkg::ASF_OP_SUB, 8'h00, 8'h80, 8'h80, 4'hA);
    alu(asf_pkg::ASF_OP_SUB, 8'h25, 8'h10, 8'h15, 4'h3);
    alu(asf_pkg::ASF_OP_LOG, 8'h00, 8'h00, 8'h00, 4'h7);
    alu(asf_pkg::ASF_OP_LOG, 8'h5A, 8'h00, 8'h5A, 4'h3);
    alu(asf_pkg::ASF_OP_PASS, 8'h00, 8'h00, 8'h00, 4'h3);
    test_override();
    reg_wr(8'h04, 8'h1F);
    reg_rd(8'h04, 8'h1F);
    end_of_test();
  end

  initial begin
    #20000;
    err_count++;
    end_of_test();
  end
endmodule : asf_status_test

//--- verilog/asf_pkg.sv
// Package for the ALU status and pointer mode block
package asf_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ALU_FLAGS_AND_POINTER_MODES_OFFSET = 8'h04;
  localparam logic [3:0] MODE_RESET_VAL = 4'hF;
  localparam logic [3:0] FLAG_RESET_VAL = 4'h0;
  localparam logic [7:0] PTR_RESET_VAL  = 8'h00;
  localparam logic [7:0] OUT_RESET_VAL  = 8'h00;

  // Bit positions
  localparam int PTR1_MODE_HI_POS = 7;
  localparam int PTR1_MODE_LO_POS = 6;
  localparam int PTR0_MODE_HI_POS = 5;
  localparam int PTR0_MODE_LO_POS = 4;
  localparam int OVF_POS          = 3;
  localparam int ZERO_POS         = 2;
  localparam int DCARRY_POS       = 1;
  localparam int CARRY_POS        = 0;

  // Pointer mode codes
  localparam logic [1:0] PMODE_DEC = 2'h0;
  localparam logic [1:0] PMODE_INC = 2'h1;

  // ----------------------------------------------------------------
  // ALU operations
  // ----------------------------------------------------------------
  typedef enum logic [6:0] {
    ASF_OP_NONE = 7'h01,
    ASF_OP_ADD  = 7'h02,
    ASF_OP_SUB  = 7'h04,
    ASF_OP_LOG  = 7'h08,
    ASF_OP_RLC  = 7'h10,
    ASF_OP_RRC  = 7'h20,
    ASF_OP_PASS = 7'h40
  } asf_op_e;

  // Operation request from execution logic
  typedef struct packed {
    asf_op_e    op;
    logic [7:0] a;
    logic [7:0] b;
  } asf_req_s;

  // Result back to execution logic
  typedef struct packed {
    logic [7:0] result;
    logic [3:0] flags;
  } asf_res_s;

  // Register bus
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } asf_bus_s;

endpackage : asf_pkg

//--- verilog/asf_status.sv
// ALU status flags and indirect pointer mode register
`timescale 1ns/10ps

// Functional notes
// - Pointer-0 mode 00 decrements pointer A after each indirect access.
// - Pointer-0 mode 01 increments pointer A after each indirect access.
// - Pointer-0 mode 1x holds pointer A unchanged.
// - Add and subtract set overflow when signed result flips sign wrongly, else clear it; other ops keep it.
// - Subtraction adds the two's complement; carry comes from that add.
// - Carry set on carry out of the top bit; inverted sense means borrow.
// - Rotate through carry loads carry with the bit shifted out.
// - Flag-affecting ops override a data write of the flags here.
// - Overflow set when signed result exceeds +127 or falls below -128.
module asf_status (
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              rst_n,
  input  wire logic              clk_en,
  // Register port
  input  wire asf_pkg::asf_bus_s bus,
  output logic [7:0]             rdata,
  // ALU request and result
  input  wire asf_pkg::asf_req_s req,
  output asf_pkg::asf_res_s      res,
  // Indirect pointers
  input  wire logic              acc_a,
  input  wire logic              acc_b,
  input  wire logic              ptr_a_wr,
  input  wire logic              ptr_b_wr,
  input  wire logic [7:0]        ptr_wdata,
  output logic [7:0]             indirect_pointer_a,
  output logic [7:0]             indirect_pointer_b,
  // Register contents
  output logic [7:0]             status
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [3:0] mode_q;
  logic [3:0] mode_d;
  logic [3:0] flag_q;
  logic [3:0] flag_d;
  logic [7:0] ptr_a_q;
  logic [7:0] ptr_a_d;
  logic [7:0] ptr_b_q;
  logic [7:0] ptr_b_d;
  logic [7:0] rdata_q;
  logic [7:0] res_q;

  // ----------------------------------------------------------------
  // Arithmetic
  // ----------------------------------------------------------------
  wire logic       is_add  = (req.op == asf_pkg::ASF_OP_ADD);
  wire logic       is_sub  = (req.op == asf_pkg::ASF_OP_SUB);
  wire logic       is_arith = is_add | is_sub;
  wire logic       is_rlc  = (req.op == asf_pkg::ASF_OP_RLC);
  wire logic       is_rrc  = (req.op == asf_pkg::ASF_OP_RRC);
  wire logic       is_log  = (req.op == asf_pkg::ASF_OP_LOG);
  wire logic       affects = is_arith | is_rlc | is_rrc | is_log;
  // Inverted operand plus carry-in forms the two's complement in one adder
  wire logic [7:0] opnd_b  = is_sub ? ~req.b : req.b;
  wire logic [8:0] cin     = {8'h00, is_sub};
  wire logic [8:0] sum     = {1'b0, req.a} + {1'b0, opnd_b} + cin;
  wire logic [4:0] nib     = {1'b0, req.a[3:0]} + {1'b0, opnd_b[3:0]} + cin[4:0];
  wire logic       cy      = sum[8];
  wire logic       dcy     = nib[4];
  wire logic       ovf     = (req.a[7] == opnd_b[7]) & (sum[7] != req.a[7]);
  wire logic [7:0] rot_l   = {req.a[6:0], flag_q[asf_pkg::CARRY_POS]};
  wire logic [7:0] rot_r   = {flag_q[asf_pkg::CARRY_POS], req.a[7:1]};
  wire logic [7:0] result  = is_arith ? sum[7:0] : is_rlc ? rot_l : is_rrc ? rot_r : req.a;
  wire logic       zero    = (result == 8'h00);
  wire logic       rot_out = is_rlc ? req.a[7] : req.a[0];

  // Flags after the operation; borrow reads as carry of the complement add
  wire logic [3:0] op_flags = is_arith ? {ovf, zero, dcy, cy} :
                              (is_rlc | is_rrc) ? {flag_q[3], zero, flag_q[1], rot_out} :
                              {flag_q[3], zero, flag_q[1:0]};

  // ----------------------------------------------------------------
  // Register port decode
  // ----------------------------------------------------------------
  wire logic hit_wr = bus.wr & (bus.addr == asf_pkg::ALU_FLAGS_AND_POINTER_MODES_OFFSET);
  wire logic hit_rd = bus.rd & (bus.addr == asf_pkg::ALU_FLAGS_AND_POINTER_MODES_OFFSET);

  assign mode_d = hit_wr ? bus.wdata[7:4] : mode_q;
  assign flag_d = affects ? op_flags : hit_wr ? bus.wdata[3:0] : flag_q;

  // ----------------------------------------------------------------
  // Pointer stepping
  // ----------------------------------------------------------------
  wire logic [1:0] m0 = mode_q[1:0];
  wire logic [1:0] m1 = mode_q[3:2];
  wire logic [7:0] step_a = (m0 == asf_pkg::PMODE_DEC) ? ptr_a_q - 8'h01 :
                            (m0 == asf_pkg::PMODE_INC) ? ptr_a_q + 8'h01 :
                            ptr_a_q;
  wire logic [7:0] step_b = (m1 == asf_pkg::PMODE_DEC) ? ptr_b_q - 8'h01 :
                            (m1 == asf_pkg::PMODE_INC) ? ptr_b_q + 8'h01 :
                            ptr_b_q;

  assign ptr_a_d = ptr_a_wr ? ptr_wdata : acc_a ? step_a : ptr_a_q;
  assign ptr_b_d = ptr_b_wr ? ptr_wdata : acc_b ? step_b : ptr_b_q;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      mode_q  <= asf_pkg::MODE_RESET_VAL;
      flag_q  <= asf_pkg::FLAG_RESET_VAL;
      ptr_a_q <= asf_pkg::PTR_RESET_VAL;
      ptr_b_q <= asf_pkg::PTR_RESET_VAL;
      rdata_q <= asf_pkg::OUT_RESET_VAL;
      res_q   <= asf_pkg::OUT_RESET_VAL;
    end else if (clk_en) begin
      mode_q  <= mode_d;
      flag_q  <= flag_d;
      ptr_a_q <= ptr_a_d;
      ptr_b_q <= ptr_b_d;
      rdata_q <= hit_rd ? {mode_q, flag_q} : 8'h00;
      res_q   <= result;
    end
  end

  assign rdata              = rdata_q;
  assign res                = '{result: res_q, flags: flag_q};
  assign indirect_pointer_a = ptr_a_q;
  assign indirect_pointer_b = ptr_b_q;
  assign status             = {mode_q, flag_q};

  // ----------------------------------------------------------------
  // Sign-extended reference sums for the overflow checks
  // ----------------------------------------------------------------
  wire logic [8:0] chk_add = {req.a[7], req.a} + {req.b[7], req.b};
  wire logic [8:0] chk_sub = {req.a[7], req.a} - {req.b[7], req.b};

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  ptr_a_dec_a: assert property (clk_en && acc_a && !ptr_a_wr && mode_q[1:0] == 2'h0 |=>
    ptr_a_q == $past(ptr_a_q) - 8'h01) else $error("pointer A not decremented");
  ptr_a_inc_a: assert property (clk_en && acc_a && !ptr_a_wr && mode_q[1:0] == 2'h1 |=>
    ptr_a_q == $past(ptr_a_q) + 8'h01) else $error("pointer A not incremented");
  ptr_a_hold_a: assert property (clk_en && acc_a && !ptr_a_wr && mode_q[1] |=>
    $stable(ptr_a_q)) else $error("pointer A changed in hold mode");
  ptr_b_mode_a: assert property (clk_en && acc_b && !ptr_b_wr && mode_q[3:2] == 2'h1 |=>
    ptr_b_q == $past(ptr_b_q) + 8'h01) else $error("pointer B not incremented");
  ptr_b_dec_a: assert property (clk_en && acc_b && !ptr_b_wr && mode_q[3:2] == 2'h0 |=>
    ptr_b_q == $past(ptr_b_q) - 8'h01) else $error("pointer B not decremented");
  ptr_b_hold_a: assert property (clk_en && acc_b && !ptr_b_wr && mode_q[3] |=>
    $stable(ptr_b_q)) else $error("pointer B changed in hold mode");
  ptr_a_load_a: assert property (clk_en && ptr_a_wr |=>
    ptr_a_q == $past(ptr_wdata)) else $error("pointer A load lost");
  ptr_b_load_a: assert property (clk_en && ptr_b_wr |=>
    ptr_b_q == $past(ptr_wdata)) else $error("pointer B load lost");

  // ----------------------------------------------------------------
  // Flag assertions
  // ----------------------------------------------------------------
  ovf_flag_a: assert property (clk_en && is_add && req.a == 8'h7F && req.b == 8'h01 |=>
    flag_q[3]) else $error("overflow not set");
  sub_carry_a: assert property (clk_en && is_sub && req.a == req.b |=>
    flag_q[0] && flag_q[2]) else $error("equal subtract must not borrow");
  add_carry_a: assert property (clk_en && is_add |=>
    flag_q[0] == ($past(req.a) + 9'h000 + $past(req.b) > 9'h0FF)) else $error("carry wrong");
  rot_carry_a: assert property (clk_en && is_rlc |=>
    flag_q[0] == $past(req.a[7])) else $error("rotate carry wrong");
  dc_flag_a: assert property (clk_en && is_add |=>
    flag_q[1] == ($past(req.a[3:0]) + 5'h00 + $past(req.b[3:0]) > 5'h0F)) else $error("dc wrong");
  zero_flag_a: assert property (clk_en && affects |=>
    flag_q[2] == ($past(result) == 8'h00)) else $error("zero flag wrong");
  flag_write_a: assert property (clk_en && hit_wr && affects |=>
    flag_q == $past(op_flags)) else $error("flag write not suppressed");
  ovf_neg_a: assert property (clk_en && is_sub && req.a == 8'h80 && req.b == 8'h01 |=>
    flag_q[3]) else $error("negative overflow not set");
  rrc_carry_a: assert property (clk_en && is_rrc |=>
    flag_q[0] == $past(req.a[0])) else $error("right rotate carry wrong");
  sub_borrow_a: assert property (clk_en && is_sub |=>
    flag_q[0] == ($past(req.a) >= $past(req.b))) else $error("borrow sense wrong");
  sub_dc_a: assert property (clk_en && is_sub |=>
    flag_q[1] == ($past(req.a[3:0]) >= $past(req.b[3:0]))) else $error("digit borrow wrong");
  ovf_add_a: assert property (clk_en && is_add |=>
    flag_q[3] == $past(chk_add[8] ^ chk_add[7])) else $error("add overflow wrong");
  ovf_sub_a: assert property (clk_en && is_sub |=>
    flag_q[3] == $past(chk_sub[8] ^ chk_sub[7])) else $error("subtract overflow wrong");
  add_res_a: assert property (clk_en && is_add |=>
    res.result == $past(req.a) + $past(req.b)) else $error("sum wrong");
  sub_res_a: assert property (clk_en && is_sub |=>
    res.result == $past(req.a) - $past(req.b)) else $error("difference wrong");
  rlc_res_a: assert property (clk_en && is_rlc |=>
    res.result == {$past(req.a[6:0]), $past(flag_q[0])}) else $error("left rotate wrong");
  rrc_res_a: assert property (clk_en && is_rrc |=>
    res.result == {$past(flag_q[0]), $past(req.a[7:1])}) else $error("right rotate wrong");
  rot_keep_a: assert property (clk_en && (is_rlc || is_rrc || is_log) |=>
    $stable(flag_q[3]) && $stable(flag_q[1])) else $error("kept flags changed");
  pass_keep_a: assert property (clk_en && !affects && !hit_wr |=>
    $stable(flag_q)) else $error("flags changed without an operation");

  // ----------------------------------------------------------------
  // Register port assertions
  // ----------------------------------------------------------------
  mode_write_a: assert property (clk_en && hit_wr |=>
    mode_q == $past(bus.wdata[7:4])) else $error("mode bits not written");
  state_freeze_a: assert property (!clk_en |=>
    $stable(status) && $stable(ptr_a_q) && $stable(ptr_b_q) && $stable(rdata))
    else $error("state moved while frozen");
  rdata_val_a: assert property (clk_en && hit_rd |=>
    rdata == $past(status)) else $error("read data wrong");
  rdata_idle_a: assert property (clk_en && !hit_rd |=>
    rdata == 8'h00) else $error("read data not cleared");

  // ----------------------------------------------------------------
  // Coverage
  // ----------------------------------------------------------------
  add_cov_c: cover property (clk_en && is_add && cy);
  sub_cov_c: cover property (clk_en && is_sub && !cy);
  rot_cov_c: cover property (clk_en && is_rrc);
  ptr_cov_c: cover property (clk_en && acc_a && acc_b);
  ovf_cov_c: cover property (clk_en && is_sub && ovf);

endmodule : asf_status
